// [src/ocs_pkg.sv]
// constants, field codes and state type for the oscillator select block
// assumes nothing beyond a SystemVerilog compiler
package ocs_pkg;

   // initial oscillator select codes
   localparam logic [2:0] SEL_FRC_DIVN = 3'h7;
   localparam logic [2:0] SEL_FRC_DIV16 = 3'h6;
   localparam logic [2:0] SEL_LOW_POWER_RC_OSC = 3'h5;
   localparam logic [2:0] SEL_SEC = 3'h4;
   localparam logic [2:0] SEL_PRI_PLL = 3'h3;
   localparam logic [2:0] SEL_PRI = 3'h2;
   localparam logic [2:0] SEL_FRC_PLL = 3'h1;
   localparam logic [2:0] SEL_FRC = 3'h0;

   // primary oscillator mode codes
   localparam logic [1:0] PMD_HS = 2'h2;
   localparam logic [1:0] PMD_XT = 2'h1;
   localparam logic [1:0] PMD_EC = 2'h0;

   // power-on values when configuration is unprogrammed
   localparam logic [2:0] POR_SEL = SEL_FRC;
   localparam logic [1:0] POR_PMD = PMD_EC;

   // divider constants: prescale and feedback fields add a base, so field value 0 means the base factor
   localparam logic [5:0] PRE_BASE = 6'h02;
   localparam logic [9:0] FB_BASE = 10'h002;
   localparam logic [3:0] POST_DIV2 = 4'h2;
   localparam logic [3:0] POST_DIV4 = 4'h4;
   localparam logic [3:0] POST_DIV8 = 4'h8;
   localparam logic [4:0] FRC_DIV16 = 5'h10;
   localparam logic [1:0] SYS_DIV = 2'h2;

   // clock fail monitor window, in low-power rc ticks
   localparam logic [3:0] FAIL_LOW_POWER_RC_OSC_TICKS = 4'h4;

   // width of the pll input period measurement, sys clocks
   localparam int PERIOD_W = 20;

   // clock mode indices 0..11
   localparam logic [3:0] MODE_FRC_DIVN = 4'h0;
   localparam logic [3:0] MODE_FRC_DIV16 = 4'h1;
   localparam logic [3:0] MODE_LOW_POWER_RC_OSC = 4'h2;
   localparam logic [3:0] MODE_SEC = 4'h3;
   localparam logic [3:0] MODE_HS_PLL = 4'h4;
   localparam logic [3:0] MODE_XT_PLL = 4'h5;
   localparam logic [3:0] MODE_EC_PLL = 4'h6;
   localparam logic [3:0] MODE_HS = 4'h7;
   localparam logic [3:0] MODE_XT = 4'h8;
   localparam logic [3:0] MODE_EC = 4'h9;
   localparam logic [3:0] MODE_FRC_PLL = 4'ha;
   localparam logic [3:0] MODE_FRC = 4'hb;

   typedef enum logic [1:0] {
      OCS_ST_CAPTURE,
      OCS_ST_RUN,
      OCS_ST_FAILSAFE
   } ocs_state_t;

endpackage

// [src/ocs_edge_sync.sv]
// three-stage synchroniser with rising-edge tick for an oscillator pin
// assumes the pin is slower than half of sys_clk_in
`timescale 1ns/100ps
module ocs_edge_sync
(
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic pin_in,
   output logic tick_out
);
   logic meta_ff;
   logic sync2_ff;
   logic sync3_ff;
   logic level_ff;

   always_ff @(posedge sys_clk_in)
   begin
      if (!reset_n_in)
      begin
         meta_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
         level_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= pin_in;
         sync2_ff <= meta_ff;
         sync3_ff <= sync2_ff;
         if (sync2_ff == sync3_ff)
         begin
            level_ff <= sync3_ff;
         end
      end
   end

   // rise counts once the second and third stage agree on high
   assign tick_out = (sync2_ff == sync3_ff) & sync3_ff & ~level_ff;
endmodule

// [src/ocs_tick_div.sv]
// programmable divider of a tick stream, one output tick per div_in inputs
// assumes div_in is held stable while a period is meant to be exact
`timescale 1ns/100ps
module ocs_tick_div
#(
   parameter int W = 9
)
(
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic [W-1:0] div_in,
   input wire logic tick_in,
   output logic tick_out
);
   logic [W-1:0] cnt_ff;
   logic tick_ff;
   wire last_w = (cnt_ff + 1'b1) >= div_in;

   generate
      if (W < 1)
      begin : g_bad_w
         $error("ocs_tick_div: W must be at least 1");
      end
   endgenerate

   // counter reloads from zero so each period matches the field
   always_ff @(posedge sys_clk_in)
   begin
      if (!reset_n_in)
      begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end
      else
      begin
         tick_ff <= tick_in & last_w;
         if (tick_in)
         begin
            cnt_ff <= last_w ? '0 : cnt_ff + 1'b1; // R23
         end
      end
   end

   assign tick_out = tick_ff;
endmodule

// [src/ocs_top.sv]
// oscillator source selection, pll model and system clock dividers
// Overview of operation
// (R1) fast rc divided by 2 up to 256
// (R2) power-on source from select and mode fields
// (R3) unprogrammed configuration picks fast rc
// (R4) twelve clock modes encoded
// (R5) seven system clock options available; the select decode offers eight
// (R6) instruction and peripheral clock are source/2
// (R7) software keeps instruction clock below 40 MHz
// (R8) peripheral equals instruction unless doze ratio
// (R9) only primary or fast rc feed pll
// (R10) pll prescale 2 to 33, zero means 2
// (R11) software keeps vco input 0.8 to 8 MHz
// (R12) nine-bit feedback field, 0x1e gives 32
// (R13) software keeps vco output 100 to 200 MHz
// (R14) pll postscale 2, 4 or 8
// (R15) software keeps pll output 12.5 to 80 MHz
// (R16) output equals input times m over n1*n2
// (R17) low-power rc also feeds watchdog and monitor
// (R18) fast rc accepts software tuning value
// (R19) clock fail monitor forces fail-safe source
// (R20) external clock mode drives pin directly
// (R21) initial select encoding of eight sources
// (R22) primary mode encoding hs, xt, ec
// (R23) dividers are reloading synchronous counters
// oscillators arrive as pins and leave as sys_clk_in tick pulses;
// assumes the sources run well below half of 125 MHz
`timescale 1ns/100ps
module ocs_top
(
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic fast_rc_osc_in,
   input wire logic clock_input_pin_in,
   input wire logic secondary_osc_in,
   input wire logic low_power_rc_osc_in,
   input wire logic config_programmed_in,
   input wire logic [2:0] initial_osc_select_in,
   input wire logic [1:0] primary_osc_mode_in,
   input wire logic [2:0] fast_rc_divide_sel_in,
   input wire logic [4:0] pll_prescale_sel_in,
   input wire logic [8:0] pll_feedback_sel_in,
   input wire logic [1:0] pll_postscale_sel_in,
   input wire logic [5:0] fast_rc_tune_in,
   input wire logic doze_enable_in,
   input wire logic [2:0] doze_ratio_sel_in,
   input wire logic clock_fail_monitor_en_in,
   input wire logic clock_fail_clear_in,
   output logic osc_tick_out,
   output logic instruction_tick_out,
   output logic peripheral_tick_out,
   output logic wdt_ref_tick_out,
   output logic [2:0] active_source_out,
   output logic [1:0] primary_mode_out,
   output logic [3:0] clock_mode_out,
   output logic pll_active_out,
   output logic pll_lock_out,
   output logic crystal_drive_en_out,
   output logic high_speed_drive_out,
   output logic [5:0] fast_rc_tune_out,
   output logic clock_fail_out
);
   localparam int PERIOD_W = ocs_pkg::PERIOD_W;
   localparam logic [PERIOD_W-1:0] PER_MAX = '1;

   ocs_pkg::ocs_state_t state_ff;
   ocs_pkg::ocs_state_t nxt_state;
   logic [2:0] cfg_sel_ff;
   logic [1:0] cfg_pmd_ff;
   logic [5:0] tune_ff;
   logic fail_ff;
   logic [3:0] fail_cnt_ff;
   logic [PERIOD_W-1:0] per_cnt_ff;
   logic [PERIOD_W-1:0] period_ff;
   logic period_valid_ff;
   logic [PERIOD_W:0] acc_ff;
   logic vco_tick_ff;
   logic osc_tick_ff;

   // source pins {low_power_rc_osc, secondary, primary, fast rc}
   wire [3:0] src_pin_w = {low_power_rc_osc_in, secondary_osc_in,
                           clock_input_pin_in, fast_rc_osc_in};
   wire [3:0] src_tick_w;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_sync
         ocs_edge_sync u_sync
         (
            .sys_clk_in (sys_clk_in),
            .reset_n_in (reset_n_in),
            .pin_in (src_pin_w[gi]),
            .tick_out (src_tick_w[gi])
         );
      end
   endgenerate

   wire frc_tick_w = src_tick_w[0];
   wire pri_tick_w = src_tick_w[1]; // R20
   wire sec_tick_w = src_tick_w[2];
   wire low_power_rc_osc_tick_w = src_tick_w[3];

   // fail-safe overrides the captured selection with fast rc
   wire [2:0] sel_w = (state_ff == ocs_pkg::OCS_ST_FAILSAFE) ?
                      ocs_pkg::SEL_FRC : cfg_sel_ff; // R19
   wire pll_on_w = (sel_w == ocs_pkg::SEL_PRI_PLL) ||
                   (sel_w == ocs_pkg::SEL_FRC_PLL); // R9
   wire pll_src_tick_w = pll_on_w &
      ((sel_w == ocs_pkg::SEL_PRI_PLL) ? pri_tick_w : frc_tick_w); // R9

   // fast rc postscaler and fixed divide-by-16
   wire [8:0] frc_div_w = 9'h002 << fast_rc_divide_sel_in; // R1
   wire frc_divn_tick_w;
   wire frc_div16_tick_w;

   ocs_tick_div #(.W(9)) u_frc_divn
   (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .div_in (frc_div_w),
      .tick_in (frc_tick_w),
      .tick_out (frc_divn_tick_w)
   );

   ocs_tick_div #(.W(5)) u_frc_div16
   (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .div_in (ocs_pkg::FRC_DIV16),
      .tick_in (frc_tick_w),
      .tick_out (frc_div16_tick_w)
   );

   // pll input prescaler
   wire [5:0] pre_div_w = {1'b0, pll_prescale_sel_in} +
                          ocs_pkg::PRE_BASE; // R10
   wire pre_tick_w;

   ocs_tick_div #(.W(6)) u_pll_pre
   (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .div_in (pre_div_w),
      .tick_in (pll_src_tick_w),
      .tick_out (pre_tick_w)
   );

   // vco modelled as a rate multiplier: m ticks per measured period;
   // limitation: saturates at one tick per sys clock
   wire [9:0] mult_w = {1'b0, pll_feedback_sel_in} +
                       ocs_pkg::FB_BASE; // R12
   wire [PERIOD_W:0] acc_sum_w = acc_ff + {{(PERIOD_W-9){1'b0}}, mult_w};
   wire [PERIOD_W:0] per_ext_w = {1'b0, period_ff};
   wire vco_hit_w = period_valid_ff && pll_on_w &&
                    (acc_sum_w >= per_ext_w); // R16
   wire [PERIOD_W:0] acc_left_w = acc_sum_w - per_ext_w;
   wire [PERIOD_W:0] nxt_acc = !pll_on_w ? '0 :
      !vco_hit_w ? acc_sum_w :
      (acc_left_w >= per_ext_w) ? per_ext_w - 1'b1 : acc_left_w;

   always_ff @(posedge sys_clk_in)
   begin
      if (!reset_n_in)
      begin
         per_cnt_ff <= '0;
         period_ff <= '0;
         period_valid_ff <= 1'b0;
         acc_ff <= '0;
         vco_tick_ff <= 1'b0;
      end
      else
      begin
         acc_ff <= nxt_acc;
         vco_tick_ff <= vco_hit_w;
         if (!pll_on_w)
         begin
            per_cnt_ff <= '0;
            period_valid_ff <= 1'b0;
         end
         else if (pre_tick_w)
         begin
            per_cnt_ff <= '0;
            period_ff <= per_cnt_ff + 1'b1;
            period_valid_ff <= 1'b1;
         end
         else if (per_cnt_ff != PER_MAX)
         begin
            per_cnt_ff <= per_cnt_ff + 1'b1;
         end
      end
   end

   // pll postscaler, field 3 also divides by 8
   wire [3:0] post_div_w =
      (pll_postscale_sel_in == 2'h0) ? ocs_pkg::POST_DIV2 :
      (pll_postscale_sel_in == 2'h1) ? ocs_pkg::POST_DIV4 :
      ocs_pkg::POST_DIV8; // R14
   wire pll_tick_w;

   ocs_tick_div #(.W(4)) u_pll_post
   (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .div_in (post_div_w),
      .tick_in (vco_tick_ff),
      .tick_out (pll_tick_w)
   );

   // selected system oscillator tick
   logic osc_sel_tick;
   always_comb
   begin
      case (sel_w) // R5 R21
         ocs_pkg::SEL_FRC_DIVN: osc_sel_tick = frc_divn_tick_w;
         ocs_pkg::SEL_FRC_DIV16: osc_sel_tick = frc_div16_tick_w;
         ocs_pkg::SEL_LOW_POWER_RC_OSC: osc_sel_tick = low_power_rc_osc_tick_w;
         ocs_pkg::SEL_SEC: osc_sel_tick = sec_tick_w;
         ocs_pkg::SEL_PRI_PLL: osc_sel_tick = pll_tick_w;
         ocs_pkg::SEL_PRI: osc_sel_tick = pri_tick_w;
         ocs_pkg::SEL_FRC_PLL: osc_sel_tick = pll_tick_w;
         default: osc_sel_tick = frc_tick_w;
      endcase
   end

   // raw tick of the running source, watched by the fail monitor
   logic mon_tick;
   always_comb
   begin
      case (sel_w)
         ocs_pkg::SEL_SEC: mon_tick = sec_tick_w;
         ocs_pkg::SEL_PRI, ocs_pkg::SEL_PRI_PLL: mon_tick = pri_tick_w;
         default: mon_tick = frc_tick_w;
      endcase
   end

   // instruction and peripheral time base
   wire periph_tick_w;
   wire cpu_doze_tick_w;
   wire [7:0] doze_div_w = 8'h01 << doze_ratio_sel_in;

   ocs_tick_div #(.W(2)) u_sys_div
   (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .div_in (ocs_pkg::SYS_DIV),
      .tick_in (osc_tick_ff),
      .tick_out (periph_tick_w)
   ); // R6

   ocs_tick_div #(.W(8)) u_doze
   (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .div_in (doze_div_w),
      .tick_in (periph_tick_w),
      .tick_out (cpu_doze_tick_w)
   );

   // ratio 1:1 bypasses the doze divider so both ticks coincide
   wire doze_on_w = doze_enable_in && (doze_ratio_sel_in != 3'h0);

   // clock fail monitor: low_power_rc_osc ticks without a source edge
   wire mon_en_w = clock_fail_monitor_en_in &&
                   (state_ff == ocs_pkg::OCS_ST_RUN) &&
                   (cfg_sel_ff != ocs_pkg::SEL_LOW_POWER_RC_OSC);
   wire fail_hit_w = mon_en_w && low_power_rc_osc_tick_w &&
      (fail_cnt_ff + 1'b1 >= ocs_pkg::FAIL_LOW_POWER_RC_OSC_TICKS); // R17 R19

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ocs_pkg::OCS_ST_CAPTURE: nxt_state = ocs_pkg::OCS_ST_RUN;
         ocs_pkg::OCS_ST_RUN:
            if (fail_hit_w)
            begin
               nxt_state = ocs_pkg::OCS_ST_FAILSAFE; // R19
            end
         ocs_pkg::OCS_ST_FAILSAFE: nxt_state = ocs_pkg::OCS_ST_FAILSAFE;
         default: nxt_state = ocs_pkg::OCS_ST_CAPTURE;
      endcase
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (!reset_n_in)
      begin
         state_ff <= ocs_pkg::OCS_ST_CAPTURE;
         cfg_sel_ff <= ocs_pkg::POR_SEL;
         cfg_pmd_ff <= ocs_pkg::POR_PMD;
         tune_ff <= 6'h00;
         fail_ff <= 1'b0;
         fail_cnt_ff <= 4'h0;
         osc_tick_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         osc_tick_ff <= osc_sel_tick;
         tune_ff <= fast_rc_tune_in; // R18
         // configuration caught once, the cycle after reset release
         if (state_ff == ocs_pkg::OCS_ST_CAPTURE)
         begin
            cfg_sel_ff <= config_programmed_in ?
                          initial_osc_select_in : ocs_pkg::POR_SEL; // R2 R3
            cfg_pmd_ff <= config_programmed_in ?
                          primary_osc_mode_in : ocs_pkg::POR_PMD; // R2 R3
         end
         if (!mon_en_w || mon_tick)
         begin
            fail_cnt_ff <= 4'h0;
         end
         else if (low_power_rc_osc_tick_w && !fail_hit_w)
         begin
            fail_cnt_ff <= fail_cnt_ff + 1'b1;
         end
         // set wins over a clear in the same cycle
         if (fail_hit_w)
         begin
            fail_ff <= 1'b1;
         end
         else if (clock_fail_clear_in)
         begin
            fail_ff <= 1'b0;
         end
      end
   end

   // twelve clock modes from select and primary mode
   wire is_pri_w = (sel_w == ocs_pkg::SEL_PRI) ||
                   (sel_w == ocs_pkg::SEL_PRI_PLL);
   wire pmd_hs_w = (cfg_pmd_ff == ocs_pkg::PMD_HS); // R22
   wire pmd_xt_w = (cfg_pmd_ff == ocs_pkg::PMD_XT); // R22
   logic [3:0] mode;
   always_comb
   begin
      case (sel_w) // R4
         ocs_pkg::SEL_FRC_DIVN: mode = ocs_pkg::MODE_FRC_DIVN;
         ocs_pkg::SEL_FRC_DIV16: mode = ocs_pkg::MODE_FRC_DIV16;
         ocs_pkg::SEL_LOW_POWER_RC_OSC: mode = ocs_pkg::MODE_LOW_POWER_RC_OSC;
         ocs_pkg::SEL_SEC: mode = ocs_pkg::MODE_SEC;
         ocs_pkg::SEL_PRI_PLL:
            mode = pmd_hs_w ? ocs_pkg::MODE_HS_PLL :
                   pmd_xt_w ? ocs_pkg::MODE_XT_PLL : ocs_pkg::MODE_EC_PLL;
         ocs_pkg::SEL_PRI:
            mode = pmd_hs_w ? ocs_pkg::MODE_HS :
                   pmd_xt_w ? ocs_pkg::MODE_XT : ocs_pkg::MODE_EC;
         ocs_pkg::SEL_FRC_PLL: mode = ocs_pkg::MODE_FRC_PLL;
         default: mode = ocs_pkg::MODE_FRC;
      endcase
   end

   assign osc_tick_out = osc_tick_ff;
   assign peripheral_tick_out = periph_tick_w;
   assign instruction_tick_out = doze_on_w ?
                                 cpu_doze_tick_w : periph_tick_w; // R8
   assign wdt_ref_tick_out = low_power_rc_osc_tick_w; // R17
   assign active_source_out = sel_w;
   assign primary_mode_out = cfg_pmd_ff;
   assign clock_mode_out = mode;
   assign pll_active_out = pll_on_w;
   assign pll_lock_out = period_valid_ff;
   assign crystal_drive_en_out = is_pri_w && (pmd_hs_w || pmd_xt_w); // R20
   assign high_speed_drive_out = is_pri_w && pmd_hs_w;
   assign fast_rc_tune_out = tune_ff;
   assign clock_fail_out = fail_ff;
endmodule

// [verification/ocs_top_properties.sv]
// concurrent checks on the oscillator select block ports
// assumes the top module ocs_top and package ocs_pkg are compiled first
`timescale 1ns/100ps
module ocs_top_props
(
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic config_programmed_in,
   input wire logic [2:0] initial_osc_select_in,
   input wire logic [1:0] primary_osc_mode_in,
   input wire logic [5:0] fast_rc_tune_in,
   input wire logic doze_enable_in,
   input wire logic clock_fail_clear_in,
   input wire logic osc_tick_out,
   input wire logic instruction_tick_out,
   input wire logic peripheral_tick_out,
   input wire logic [2:0] active_source_out,
   input wire logic [1:0] primary_mode_out,
   input wire logic pll_active_out,
   input wire logic pll_lock_out,
   input wire logic crystal_drive_en_out,
   input wire logic high_speed_drive_out,
   input wire logic [5:0] fast_rc_tune_out,
   input wire logic clock_fail_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   logic osc_odd_ff;
   wire pri_sel = active_source_out == ocs_pkg::SEL_PRI ||
      active_source_out == ocs_pkg::SEL_PRI_PLL;

   // parity of osc ticks, reset alongside the design divider
   always_ff @(posedge sys_clk_in)
      if (!reset_n_in)
         osc_odd_ff <= 1'b0;
      else if (osc_tick_out)
         osc_odd_ff <= ~osc_odd_ff;

   a_pll_route_only: assert property (pll_active_out ==
      (active_source_out == ocs_pkg::SEL_FRC_PLL ||
      active_source_out == ocs_pkg::SEL_PRI_PLL))
      else $error("pll path on a source that cannot feed it");
   a_config_capture: assert property ($rose(reset_n_in)
      && config_programmed_in |=>
      active_source_out == $past(initial_osc_select_in))
      else $error("captured select differs from configuration");
   a_unprog_fast_rc: assert property ($rose(reset_n_in)
      && !config_programmed_in |=> active_source_out == ocs_pkg::SEL_FRC)
      else $error("unprogrammed start not on fast rc");
   a_mode_capture: assert property ($rose(reset_n_in)
      && config_programmed_in && primary_osc_mode_in != 2'h3 |=>
      primary_mode_out == $past(primary_osc_mode_in))
      else $error("captured primary mode wrong");
   a_hs_drive_rule: assert property (high_speed_drive_out ==
      (pri_sel && primary_mode_out == ocs_pkg::PMD_HS))
      else $error("high speed drive mismatch");
   a_crystal_drive: assert property (crystal_drive_en_out == (pri_sel &&
      (primary_mode_out == ocs_pkg::PMD_HS ||
      primary_mode_out == ocs_pkg::PMD_XT)))
      else $error("crystal drive on in external clock mode");
   a_periph_half_rate: assert property (peripheral_tick_out ==
      $past(osc_tick_out && osc_odd_ff))
      else $error("peripheral tick not every second osc tick");
   a_instr_equals_periph: assert property ((!doze_enable_in) [*2] |->
      instruction_tick_out == peripheral_tick_out)
      else $error("instruction tick differs without doze");
   a_tune_follows: assert property ($past(reset_n_in) |->
      fast_rc_tune_out == $past(fast_rc_tune_in))
      else $error("tune value not passed on");
   a_fail_to_fast_rc: assert property ($rose(clock_fail_out) |=>
      (active_source_out == ocs_pkg::SEL_FRC) [*4])
      else $error("fail-safe did not move to fast rc");
   a_fail_flag_sticky: assert property (clock_fail_out &&
      !clock_fail_clear_in |=> clock_fail_out)
      else $error("fail flag dropped without clear");
   a_lock_needs_pll: assert property ((!pll_active_out) [*2] |->
      !pll_lock_out)
      else $error("lock without pll path");

   c_pll_lock: cover property ($rose(pll_lock_out));
   c_fail_seen: cover property ($rose(clock_fail_out));
   c_doze_tick: cover property (doze_enable_in && peripheral_tick_out);
endmodule

bind ocs_top ocs_top_props ocs_top_props_i (.*);

// [verification/test_ocs_top.sv]
// self-checking bench for the oscillator select block
// assumes the design and the checker are compiled before it
`timescale 1ns/100ps
module test_ocs_top;
   logic sys_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic config_programmed_in = 1'b1;
   logic [2:0] initial_osc_select_in = 3'h0;
   logic [1:0] primary_osc_mode_in = 2'h0;
   logic [2:0] fast_rc_divide_sel_in = 3'h0;
   logic [4:0] pll_prescale_sel_in = 5'h00;
   logic [8:0] pll_feedback_sel_in = 9'h01e;
   logic [1:0] pll_postscale_sel_in = 2'h0;
   logic [5:0] fast_rc_tune_in = 6'h00;
   logic doze_enable_in = 1'b0;
   logic [2:0] doze_ratio_sel_in = 3'h0;
   logic clock_fail_monitor_en_in = 1'b0;
   logic clock_fail_clear_in = 1'b0;
   logic osc_tick_out, instruction_tick_out, peripheral_tick_out;
   logic wdt_ref_tick_out, pll_active_out, pll_lock_out, clock_fail_out;
   logic crystal_drive_en_out, high_speed_drive_out;
   logic [2:0] active_source_out;
   logic [1:0] primary_mode_out;
   logic [3:0] clock_mode_out;
   logic [5:0] fast_rc_tune_out;
   logic [3:0] pin = 4'h0;
   int half [4] = '{4, 5, 6, 6};
   int ph [4] = '{0, 0, 0, 0};
   int n_osc, n_per, n_ins, n_wdt, cyc, failures, checks;
   int pre [4] = '{0, 3, 0, 0};
   int fb [4] = '{30, 30, 30, 14};
   int post [4] = '{0, 0, 1, 3};
   int n2;
   wire fast_rc_osc_in = pin[0];
   wire clock_input_pin_in = pin[1];
   wire secondary_osc_in = pin[2];
   wire low_power_rc_osc_in = pin[3];

   ocs_top ocs_top_i (.*);

   always #4 sys_clk_in = ~sys_clk_in;

   // oscillator pins as slow square waves; half period 0 stops a pin
   always @(negedge sys_clk_in)
      for (int i = 0; i < 4; i++)
         if (half[i] > 0)
         begin
            ph[i] = ph[i] + 1;
            if (ph[i] >= half[i])
            begin
               ph[i] = 0;
               pin[i] = ~pin[i];
            end
         end

   always @(posedge sys_clk_in)
   begin
      n_osc += int'(osc_tick_out === 1'b1);
      n_per += int'(peripheral_tick_out === 1'b1);
      n_ins += int'(instruction_tick_out === 1'b1);
      n_wdt += int'(wdt_ref_tick_out === 1'b1);
      cyc++;
      if (cyc > 60000)
      begin
         failures++;
         summarize();
      end
   end

   task automatic boot(logic prog, logic [2:0] sel, logic [1:0] pmd);
      @(negedge sys_clk_in);
      reset_n_in = 1'b0;
      config_programmed_in = prog;
      initial_osc_select_in = sel;
      primary_osc_mode_in = pmd;
      repeat (12) @(negedge sys_clk_in);
      reset_n_in = 1'b1;
      repeat (3) @(negedge sys_clk_in);
   endtask

   // clears the tick counts, then lets c cycles pass
   task automatic run(int c);
      n_osc = 0;
      n_per = 0;
      n_ins = 0;
      n_wdt = 0;
      repeat (c) @(negedge sys_clk_in);
   endtask

   task automatic chk(logic [31:0] got, logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // tick counts jitter by the pin phase, hence a tolerance
   task automatic near(int got, int exp, int tol);
      checks++;
      if (got < exp - tol || got > exp + tol)
      begin
         failures++;
         $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask

   function automatic logic [3:0] exp_mode(int s, int p);
      case (s)
         7: return ocs_pkg::MODE_FRC_DIVN;
         6: return ocs_pkg::MODE_FRC_DIV16;
         5: return ocs_pkg::MODE_LOW_POWER_RC_OSC;
         4: return ocs_pkg::MODE_SEC;
         3: return ocs_pkg::MODE_HS_PLL + 4'(2 - p);
         2: return ocs_pkg::MODE_HS + 4'(2 - p);
         1: return ocs_pkg::MODE_FRC_PLL;
         default: return ocs_pkg::MODE_FRC;
      endcase
   endfunction

   task automatic summarize();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      boot(1'b0, 3'h7, 2'h2);
      chk(active_source_out, 32'h0);
      chk(clock_mode_out, 32'(ocs_pkg::MODE_FRC));
      for (int s = 0; s < 8; s++)
         for (int p = 0; p < 3; p++)
            if (p == 1 || s == 2 || s == 3)
            begin
               boot(1'b1, 3'(s), 2'(p));
               chk(active_source_out, 32'(s));
               chk(clock_mode_out, 32'(exp_mode(s, p)));
               chk(pll_active_out, 32'(s == 1 || s == 3));
               chk(crystal_drive_en_out, 32'((s & 6) == 2 && p != 0));
               chk(high_speed_drive_out, 32'((s & 6) == 2 && p == 2));
            end
      boot(1'b1, 3'h0, 2'h1);
      run(800);
      near(n_osc, 100, 2);
      near(n_per, 50, 1);
      near(n_ins, 50, 1);
      near(n_wdt, 66, 2);
      fast_rc_tune_in = 6'h2a;
      run(2);
      chk(fast_rc_tune_out, 32'h2a);
      doze_enable_in = 1'b1;
      for (int r = 1; r < 4; r++)
      begin
         doze_ratio_sel_in = 3'(r);
         run(100);
         run(800);
         near(n_ins, 50 >> r, 1);
      end
      doze_enable_in = 1'b0;
      boot(1'b1, 3'h7, 2'h1);
      for (int k = 0; k < 8; k += 1 + k / 2 * 3)
      begin
         fast_rc_divide_sel_in = 3'(k);
         run(600);
         run(4096);
         near(n_osc, 512 >> (k + 1), 2);
      end
      boot(1'b1, 3'h6, 2'h1);
      run(4096);
      near(n_osc, 32, 2);
      half[0] = 10;
      boot(1'b1, 3'h1, 2'h1);
      for (int i = 0; i < 4; i++)
      begin
         pll_prescale_sel_in = 5'(pre[i]);
         pll_feedback_sel_in = 9'(fb[i]);
         pll_postscale_sel_in = 2'(post[i]);
         n2 = post[i] == 0 ? 2 : (post[i] == 1 ? 4 : 8);
         run(400);
         run(2000);
         chk(pll_lock_out, 32'h1);
         near(n_osc, 100 * (fb[i] + 2) / ((pre[i] + 2) * n2), 8);
      end
      half[0] = 4;
      boot(1'b1, 3'h2, 2'h1);
      clock_fail_monitor_en_in = 1'b1;
      run(300);
      chk(clock_fail_out, 32'h0);
      half[1] = 0;
      run(300);
      chk(clock_fail_out, 32'h1);
      chk(active_source_out, 32'h0);
      clock_fail_clear_in = 1'b1;
      run(1);
      clock_fail_clear_in = 1'b0;
      run(2);
      chk(clock_fail_out, 32'h0);
      chk(active_source_out, 32'h0);
      summarize();
   end
endmodule
